// *** hdl/fsr_flash_ctrl_security_regs.sv ***
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "fsr_params.svh"
// Function
// - ratio_written_flag clears on reset, sets on write
// - no program or erase until flag set
// - prescale_by_eight picks bus clock or clock/8
// - divider divides selected clock by ratio plus one
// - timing pulse is one flash clock period
// - pulse length stays between 5 and 6.7 us
// - option shadow loaded from source word at reset
// - backdoor_allowed zero never releases security by key
// - key bytes only from secure firmware, not debug
// - matching in-order eight-byte key releases security
// - redirect_off one disables vector redirection
// - only lock code 1:0 means unsecured
// - secured state blocks unsecured memory access
// - key match or blank check sets code 1:0
// - key_compare_enable steers key range writes
// - clearing key_compare_enable triggers key comparison
// - early program or erase sets sequence_error_flag
module fsr_flash_ctrl_security_regs (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic [7:0]         option_source_word,
	input  wire logic [63:0]        stored_unlock_key,
	input  wire fsr_pkg::fsr_key_wr_s key_wr,
	input  wire logic               cmd_req,
	input  wire logic               blank_pass,
	output logic                    cmd_start,
	output logic                    cmd_grant,
	output logic                    flash_tick,
	output fsr_pkg::fsr_sec_s       sec
);

	// Divider value for a given ratio register content.
	function automatic logic [9:0] div_cycles(input logic [7:0] r);
		logic [9:0] base;
		base = {4'h0, r[5:0]} + 10'h001;
		div_cycles = r[`FSR_RATIO_PRE8] ? (base << 3) : base;
	endfunction

	// Address match against one register offset.
	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a == ofs);
	endfunction

	logic [7:0]        ratio_q;    // Clock ratio register.
	logic [7:0]        option_q;   // Option shadow register.
	logic              opt_load_q; // Option shadow still waits for its load.
	logic [7:0]        config_q;   // Configuration register.
	logic              seqerr_q;   // Sticky sequence error flag.
	logic              open_q;     // Security released until the next reset.
	logic [2:0]        pre_q;      // Divide-by-eight prescaler.
	logic [5:0]        div_q;      // Ratio counter.
	logic [63:0]       key_q;      // Captured comparison bytes.
	logic [3:0]        kcnt_q;     // Bytes captured in order.
	logic              kbad_q;     // A byte came out of order or from a bad source.
	fsr_pkg::fsr_key_e kst_q;      // Key capture state.
	logic              wr_en;      // APB write access phase.
	logic              pre_done;   // Prescaler output edge.
	logic [1:0]        lock_code;  // Effective lock state code.
	logic              keycmp_fall; // Key compare enable being cleared.

	// The slave answers in the first access cycle.
	assign pready = 1'b1;
	assign wr_en  = psel & penable & pwrite;

	// Unmapped offsets answer with an error.
	assign pslverr = psel & penable & ~(hit(paddr, `FSR_OFS_RATIO) | hit(paddr, `FSR_OFS_OPTION)
		| hit(paddr, `FSR_OFS_CONFIG) | hit(paddr, `FSR_OFS_STATUS));

	// Clock ratio register; the written flag is set by any write and never by data.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ratio_q <= `FSR_RATIO_RST;
		end else if (wr_en && hit(paddr, `FSR_OFS_RATIO)) begin
			ratio_q <= {1'b1, pwdata[6:0]};
		end
	end

	// Option shadow is loaded once, on the first edge after reset release.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			option_q   <= `FSR_OPTION_RST;
			opt_load_q <= 1'b1;
		end else if (opt_load_q) begin
			option_q   <= option_source_word & `FSR_OPT_MASK;
			opt_load_q <= 1'b0;
		end
	end

	// Configuration register keeps only the key compare enable.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_q <= `FSR_CONFIG_RST;
		end else if (wr_en && hit(paddr, `FSR_OFS_CONFIG)) begin
			config_q <= pwdata[7:0] & `FSR_CFG_MASK;
		end
	end

	// Clearing the enable with a write is the moment to compare the key.
	assign keycmp_fall = wr_en & hit(paddr, `FSR_OFS_CONFIG)
		& config_q[`FSR_CFG_KEYCMP] & ~pwdata[`FSR_CFG_KEYCMP];

	// Prescaler runs freely; its wrap marks one eighth of the bus rate.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q <= 3'h0;
		end else begin
			pre_q <= pre_q + 3'h1;
		end
	end
	assign pre_done = ratio_q[`FSR_RATIO_PRE8] ? (pre_q == 3'h7) : 1'b1;

	// Ratio counter divides the selected clock by the field plus one.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q      <= 6'h00;
			flash_tick <= 1'b0;
		end else if (pre_done) begin
			if (div_q >= ratio_q[5:0]) begin
				div_q      <= 6'h00;
				flash_tick <= 1'b1;
			end else begin
				div_q      <= div_q + 6'h01;
				flash_tick <= 1'b0;
			end
		end else begin
			flash_tick <= 1'b0;
		end
	end

	// Program and erase requests pass only once the ratio has been written.
	assign cmd_grant = cmd_req & ratio_q[`FSR_RATIO_WRITTEN];

	// Sticky sequence error; a new refusal wins over the software clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seqerr_q <= 1'b0;
		end else if (cmd_req && !ratio_q[`FSR_RATIO_WRITTEN]) begin
			seqerr_q <= 1'b1;
		end else if (wr_en && hit(paddr, `FSR_OFS_STATUS) && pwdata[`FSR_STS_SEQERR]) begin
			seqerr_q <= 1'b0;
		end
	end

	// Key range writes start a command while compare is off.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_start <= 1'b0;
		end else begin
			cmd_start <= key_wr.valid & ~config_q[`FSR_CFG_KEYCMP];
		end
	end

	// Key capture: bytes in ascending order from secure firmware only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			kst_q  <= fsr_pkg::KEY_IDLE;
			key_q  <= 64'h0;
			kcnt_q <= 4'h0;
			kbad_q <= 1'b0;
		end else begin
			case (kst_q)
				fsr_pkg::KEY_IDLE: begin
					// Arm a fresh capture when compare gets enabled.
					if (config_q[`FSR_CFG_KEYCMP]) begin
						kst_q  <= fsr_pkg::KEY_COLLECT;
						kcnt_q <= 4'h0;
						kbad_q <= 1'b0;
					end
				end
				fsr_pkg::KEY_COLLECT: begin
					if (!config_q[`FSR_CFG_KEYCMP]) begin
						kst_q <= fsr_pkg::KEY_IDLE;
					end else if (key_wr.valid) begin
						// Debug or unsecured writes spoil the entry.
						if (!key_wr.from_secure || key_wr.from_debug
							|| ({1'b0, key_wr.idx} != kcnt_q)) begin
							kbad_q <= 1'b1;
						end else begin
							key_q[63 - 8 * key_wr.idx -: 8] <= key_wr.data;
							kcnt_q <= kcnt_q + 4'h1;
						end
					end
				end
				default: begin
					kst_q <= fsr_pkg::KEY_IDLE;
				end
			endcase
		end
	end

	// Release of security, held until the next reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			open_q <= 1'b0;
		end else if (blank_pass) begin
			open_q <= 1'b1;
		end else if (keycmp_fall && option_q[`FSR_OPT_BACKDOOR] && !kbad_q
			&& kcnt_q == 4'(`FSR_KEY_BYTES) && key_q == stored_unlock_key) begin
			open_q <= 1'b1;
		end
	end

	// Effective lock code and decoded security view.
	assign lock_code = open_q ? `FSR_LOCK_OPEN : option_q[1:0];
	always_comb begin
		sec.secured        = (lock_code != `FSR_LOCK_OPEN);
		sec.block_unsecure = sec.secured;
		sec.redirect_en    = ~option_q[`FSR_OPT_REDIR_OFF];
		sec.backdoor_ok    = option_q[`FSR_OPT_BACKDOOR];
	end

	// Read mux; reserved bits read as zero.
	always_comb begin
		prdata = 32'h0;
		if (psel && !pwrite) begin
			if (hit(paddr, `FSR_OFS_RATIO)) begin
				prdata[7:0] = ratio_q;
			end else if (hit(paddr, `FSR_OFS_OPTION)) begin
				prdata[7:0] = {option_q[7:2], lock_code};
			end else if (hit(paddr, `FSR_OFS_CONFIG)) begin
				prdata[7:0] = config_q;
			end else if (hit(paddr, `FSR_OFS_STATUS)) begin
				prdata[`FSR_STS_SEQERR]  = seqerr_q;
				prdata[`FSR_STS_SECURED] = sec.secured;
			end
		end
	end

	// Helper: cycles between flash ticks.
	logic [9:0] tick_gap_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_gap_q <= 10'h0;
		end else if (flash_tick) begin
			tick_gap_q <= 10'h1;
		end else if (tick_gap_q != 10'h3ff) begin
			tick_gap_q <= tick_gap_q + 10'h1;
		end
	end

	// Helper: ratio register stable since the last tick.
	// A write wins over a tick, so a period that straddles a change is never measured.
	logic ratio_stable_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ratio_stable_q <= 1'b0;
		end else if (wr_en && hit(paddr, `FSR_OFS_RATIO)) begin
			ratio_stable_q <= 1'b0;
		end else if (flash_tick) begin
			ratio_stable_q <= 1'b1;
		end
	end

	// A written ratio always shows the written flag on the next cycle.
	a_ratio_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && hit(paddr, `FSR_OFS_RATIO) |=> ratio_q[`FSR_RATIO_WRITTEN])
		else $error("ratio written flag not set");

	// No grant without the written flag.
	a_grant_needs_flag: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_grant |-> ratio_q[`FSR_RATIO_WRITTEN])
		else $error("command granted before ratio written");

	// Refused request raises the error flag.
	a_refuse_error: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_req && !ratio_q[`FSR_RATIO_WRITTEN] |=> seqerr_q)
		else $error("refused command did not flag error");

	// Tick spacing equals the divider setting.
	a_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
		flash_tick && ratio_stable_q && $stable(ratio_q) && tick_gap_q != 10'h0
		|-> tick_gap_q == div_cycles(ratio_q))
		else $error("flash tick period wrong");

	// Tick is a single-cycle pulse whenever the ratio field is nonzero.
	a_tick_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		flash_tick && ratio_q[5:0] != 6'h0 |=> !flash_tick)
		else $error("flash tick longer than one cycle");

	// The shadow follows the source word after the load cycle.
	a_option_load: assert property (@(posedge pclk) disable iff (!presetn)
		opt_load_q |=> option_q == (($past(option_source_word)) & `FSR_OPT_MASK))
		else $error("option shadow not loaded");

	// Release sequence: open stays set.
	sequence s_released;
		open_q;
	endsequence
	a_release_hold: assert property (@(posedge pclk) disable iff (!presetn)
		s_released |=> open_q [*8])
		else $error("security release lost");

	// Key release never happens with the backdoor barred.
	a_backdoor_bar: assert property (@(posedge pclk) disable iff (!presetn)
		!open_q && !blank_pass && !option_q[`FSR_OPT_BACKDOOR] |=> !open_q)
		else $error("security released with backdoor barred");

	// Lock decode and redirection.
	a_lock_decode: assert property (@(posedge pclk) disable iff (!presetn)
		(sec.secured == !(open_q || option_q[1:0] == `FSR_LOCK_OPEN))
		&& (sec.block_unsecure == sec.secured)
		&& (sec.redirect_en != option_q[`FSR_OPT_REDIR_OFF]))
		else $error("security decode wrong");

	// Key range writes start commands only with compare off.
	a_cmd_steer: assert property (@(posedge pclk) disable iff (!presetn)
		key_wr.valid |=> cmd_start == !$past(config_q[`FSR_CFG_KEYCMP]))
		else $error("key range write misrouted");

endmodule // fsr_flash_ctrl_security_regs

// *** include/fsr_params.svh ***
`ifndef FSR_PARAMS_SVH
`define FSR_PARAMS_SVH

// Register byte offsets on the APB side.
`define FSR_OFS_RATIO     12'h000
`define FSR_OFS_OPTION    12'h004
`define FSR_OFS_CONFIG    12'h008
`define FSR_OFS_STATUS    12'h00c

// Clock ratio register fields.
`define FSR_RATIO_WRITTEN 7
`define FSR_RATIO_PRE8    6
`define FSR_RATIO_DIV_W   6

// Option shadow fields.
`define FSR_OPT_BACKDOOR  7
`define FSR_OPT_REDIR_OFF 6
`define FSR_OPT_LOCK_W    2
`define FSR_OPT_MASK      8'hc3
`define FSR_LOCK_OPEN     2'h2

// Configuration register fields.
`define FSR_CFG_KEYCMP    5
`define FSR_CFG_MASK      8'h20

// Status register fields.
`define FSR_STS_SEQERR    0
`define FSR_STS_SECURED   1

// Reset values.
`define FSR_RATIO_RST     8'h00
`define FSR_OPTION_RST    8'hff
`define FSR_CONFIG_RST    8'h00

// Prescaler and key geometry.
`define FSR_PRE_DIV       8
`define FSR_KEY_BYTES     8

// Timing of a program or erase pulse.
`define FSR_PCLK_MHZ      20
`define FSR_PULSE_MIN_NS  5000
`define FSR_PULSE_MAX_NS  6700
`define FSR_PULSE_MIN_CYC (((`FSR_PULSE_MIN_NS * `FSR_PCLK_MHZ) + 999) / 1000)
`define FSR_PULSE_MAX_CYC ((`FSR_PULSE_MAX_NS * `FSR_PCLK_MHZ) / 1000)

`endif

// *** include/fsr_pkg.sv ***
package fsr_pkg;

	// A CPU write into the eight-byte key range.
	typedef struct packed {
		logic       valid;       // One-cycle write strobe.
		logic [2:0] idx;         // Byte position within the key range.
		logic [7:0] data;        // Byte written.
		logic       from_secure; // Write issued by code running from secure memory.
		logic       from_debug;  // Write issued through the halt debug mode port.
	} fsr_key_wr_s;

	// Decoded security view handed to the memory system.
	typedef struct packed {
		logic       secured;        // Security is engaged.
		logic       block_unsecure; // Unsecured sources must be blocked.
		logic       redirect_en;    // Interrupt vector redirection enabled.
		logic       backdoor_ok;    // Backdoor key mechanism allowed.
	} fsr_sec_s;

	// Key capture state.
	typedef enum logic [0:0] {
		KEY_IDLE,
		KEY_COLLECT
	} fsr_key_e;

endpackage

// *** sim/fsr_seq_model.sv ***
`timescale 1ns/100ps
// Stands in for the CPU key writes and the flash command sequencer.
module fsr_seq_model (
	input  wire logic            pclk,
	input  wire logic            cmd_start,
	input  wire logic            cmd_grant,
	output fsr_pkg::fsr_key_wr_s key_wr,
	output logic                 cmd_req,
	output logic                 blank_pass
);
	// Everything idle until a task drives a request.
	initial begin
		key_wr = '0;
		cmd_req = 1'b0;
		blank_pass = 1'b0;
	end

	// One key range write, then an idle cycle so writes never sit on adjacent cycles.
	task key_byte(input logic [2:0] i, input logic [7:0] d, input logic s, input logic g,
		output logic st);
		@(posedge pclk);
		key_wr <= {1'b1, i, d, s, g};
		@(posedge pclk);
		key_wr <= {1'b0, ~i, ~d, 2'b00};  // Released lines show no stale byte.
		@(posedge pclk);
		st = cmd_start;
	endtask

	// A one-cycle program or erase request; the grant is sampled while it stands.
	task req(output logic g);
		@(posedge pclk);
		cmd_req <= 1'b1;
		@(posedge pclk);
		g = cmd_grant;
		cmd_req <= 1'b0;
	endtask

	// A blank check that found the whole array erased.
	task blank();
		@(posedge pclk);
		blank_pass <= 1'b1;
		@(posedge pclk);
		blank_pass <= 1'b0;
	endtask
endmodule // fsr_seq_model

// *** sim/fsr_flash_ctrl_security_regs_test.sv ***
`timescale 1ns/100ps
`include "fsr_params.svh"
// Self-checking bench for the flash clock and security registers.
module fsr_flash_ctrl_security_regs_test;
	logic                 pclk;
	logic                 presetn;
	logic                 psel;
	logic                 penable;
	logic                 pwrite;
	logic [11:0]          paddr;
	logic [31:0]          pwdata;
	logic [31:0]          prdata;
	logic                 pready;
	logic                 pslverr;
	logic [7:0]           opt_word;
	logic [63:0]          key;
	fsr_pkg::fsr_key_wr_s key_wr;
	logic                 cmd_req;
	logic                 blank_pass;
	logic                 cmd_start;
	logic                 cmd_grant;
	logic                 flash_tick;
	fsr_pkg::fsr_sec_s    sec;
	int                   error_cnt;
	int                   cmp_count;
	logic [31:0]          exp_q[$];                                 // Expected read data.
	logic [7:0]           opts[4] = '{8'h3c, 8'h7d, 8'hbe, 8'hff};  // One per lock code.
	logic [7:0]           rv[5] = '{8'h00, 8'h03, 8'h3f, 8'h41, 8'h4c};  // Ratio settings.
	logic [7:0]           rnd;
	logic                 st;
	int                   n;
	int                   p;

	fsr_flash_ctrl_security_regs u_fsr_flash_ctrl_security_regs (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.option_source_word(opt_word), .stored_unlock_key(key), .key_wr(key_wr),
		.cmd_req(cmd_req), .blank_pass(blank_pass), .cmd_start(cmd_start),
		.cmd_grant(cmd_grant), .flash_tick(flash_tick), .sec(sec)
	);
	fsr_seq_model u_fsr_seq_model (
		.pclk(pclk), .cmd_start(cmd_start), .cmd_grant(cmd_grant), .key_wr(key_wr),
		.cmd_req(cmd_req), .blank_pass(blank_pass)
	);

	// Bus clock of 50 ns period.
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// Compares one value and counts it.
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Prints the verdict and ends the run.
	task final_report();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Pseudo-random byte source.
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	// One APB transfer; the request holds until pready is seen at a rising edge.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (k == 20) begin
			error_cnt++;
			final_report();
		end
		chk("pslverr", 32'(pslverr), 32'(err));
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Read with a noted expectation, and plain write.
	task rd(input logic [11:0] a, input logic [31:0] e, input logic err);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0, err);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 1'b0);
	endtask

	// Read data is taken at the edge where the access completes.
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && pready === 1'b1) begin
			chk("prdata", prdata, exp_q.pop_front());
		end
	end

	// Resets the block with a given option word.
	task rst(input logic [7:0] o);
		presetn <= 1'b0;
		opt_word <= o;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask

	// Counts edges up to the next flash tick.
	task wait_tick(output int c);
		for (c = 1; c <= 2000; c++) begin
			@(posedge pclk);
			if (flash_tick === 1'b1) break;
		end
		if (c > 2000) begin
			error_cnt++;
			final_report();
		end
	endtask

	// Security outputs against the expected state.
	task sec_chk(input logic s);
		chk("secured", 32'(sec.secured), 32'(s));
		chk("block_unsecure", 32'(sec.block_unsecure), 32'(s));
	endtask

	// Full key entry: arm, eight ascending bytes, disarm.
	task key_entry(input logic [63:0] k, input logic s, input logic g);
		wr(`FSR_OFS_CONFIG, 32'h20);
		for (int i = 0; i < 8; i++) begin
			u_fsr_seq_model.key_byte(3'(i), k[63 - 8 * i -: 8], s, g, st);
			chk("cmd_start", 32'(st), 32'h0);
		end
		wr(`FSR_OFS_CONFIG, 32'h0);
		repeat (2) @(posedge pclk);
	endtask

	// Main sequence.
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		opt_word = 8'h00;
		error_cnt = 0;
		cmp_count = 0;
		rnd = 8'h33;
		for (n = 0; n < 8; n++) begin
			rnd = lfsr(rnd);
			key[63 - 8 * n -: 8] = rnd;
		end
		// Every lock code, with unimplemented option bits set in the source word.
		foreach (opts[i]) begin
			rst(opts[i]);
			rd(`FSR_OFS_OPTION, 32'(opts[i] & 8'hc3), 1'b0);
			sec_chk(opts[i][1:0] != 2'b10);
			chk("redirect_en", 32'(sec.redirect_en), 32'(!opts[i][6]));
			chk("backdoor_ok", 32'(sec.backdoor_ok), 32'(opts[i][7]));
		end
		rd(`FSR_OFS_RATIO, 32'h0, 1'b0);
		rd(`FSR_OFS_CONFIG, 32'h0, 1'b0);
		rd(12'h010, 32'h0, 1'b1);
		// A request before the ratio write is refused and flagged.
		u_fsr_seq_model.req(st);
		chk("cmd_grant", 32'(st), 32'h0);
		rd(`FSR_OFS_STATUS, 32'h3, 1'b0);
		wr(`FSR_OFS_STATUS, 32'h1);
		rd(`FSR_OFS_STATUS, 32'h2, 1'b0);
		// Software writes the ratio first, as it must.
		rnd = lfsr(rnd);
		wr(`FSR_OFS_RATIO, {24'h0, rnd});
		rd(`FSR_OFS_RATIO, {24'h0, 1'b1, rnd[6:0]}, 1'b0);
		wr(`FSR_OFS_RATIO, 32'h0);
		rd(`FSR_OFS_RATIO, 32'h80, 1'b0);
		u_fsr_seq_model.req(st);
		chk("cmd_grant", 32'(st), 32'h1);
		// Tick period per ratio; the last setting is the 20 MHz one.
		foreach (rv[i]) begin
			wr(`FSR_OFS_RATIO, {24'h0, rv[i]});
			wait_tick(n);
			wait_tick(n);
			wait_tick(n);
			p = (rv[i][5:0] + 1) * (rv[i][6] ? `FSR_PRE_DIV : 1);
			chk("tick period", 32'(n), 32'(p));
		end
		chk("pulse span", 32'(n >= `FSR_PULSE_MIN_CYC && n <= `FSR_PULSE_MAX_CYC), 32'h1);
		u_fsr_seq_model.key_byte(3'h0, rnd, 1'b1, 1'b0, st);
		chk("cmd_start", 32'(st), 32'h1);
		wr(`FSR_OFS_CONFIG, 32'hff);
		rd(`FSR_OFS_CONFIG, 32'h20, 1'b0);
		wr(`FSR_OFS_CONFIG, 32'h0);
		wr(`FSR_OFS_OPTION, 32'h0);
		rd(`FSR_OFS_OPTION, 32'hc3, 1'b0);
		key_entry(key, 1'b0, 1'b1);
		sec_chk(1'b1);
		key_entry(key ^ 64'h0000_0001_0000_0000, 1'b1, 1'b0);
		sec_chk(1'b1);
		key_entry(key, 1'b1, 1'b0);
		sec_chk(1'b0);
		rd(`FSR_OFS_OPTION, 32'hc2, 1'b0);
		// Backdoor barred: only a clean blank check opens, until the next reset.
		rst(8'h7f);
		key_entry(key, 1'b1, 1'b0);
		sec_chk(1'b1);
		u_fsr_seq_model.blank();
		repeat (2) @(posedge pclk);
		sec_chk(1'b0);
		rst(8'h7f);
		sec_chk(1'b1);
		final_report();
	end
endmodule // fsr_flash_ctrl_security_regs_test
